// file: hw/rsq_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures of
 * the reset sequencer and supply monitor. Included by bare name; holds
 * definitions only.
 */
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH

// Register map, byte offsets on the AXI4-Lite slave
`define RSQ_OFS_SUPPLY_CTRL_STATUS  8'h00

// Field positions inside supply_integrity_ctrl_status
`define RSQ_BIT_AUX_IRQ_ENABLE      6
`define RSQ_BIT_AUX_LOW_FLAG        5
`define RSQ_BIT_LOW_SUPPLY_RST_FLAG 4
`define RSQ_BIT_WATCHDOG_RST_FLAG   0

// Reset values
`define RSQ_RST_STATUS_BYTE         8'h00
`define RSQ_RST_RDATA               32'h0000_0000

// AXI responses
`define RSQ_RESP_OKAY               2'h0
`define RSQ_RESP_SLVERR             2'h2

// Reset vector location, high and low byte
`define RSQ_VEC_LO                  16'hFFFE
`define RSQ_VEC_HI                  16'hFFFF

// Stabilisation delays in CPU cycles
`define RSQ_DELAY_SHORT             256
`define RSQ_DELAY_LONG              4096

// Clock rate and the watchdog output pulse figure
`define RSQ_CLK_MHZ                 200
`define RSQ_WDG_PULSE_NS            100

// Cycles the pin is ignored after release, covers rise and sync lag
`define RSQ_PIN_GUARD               3'h4

`endif

// file: hw/rsq_pkg.sv
/*
 * Types shared by the reset sequencer files: sequence states and the
 * bundles of reset causes and status fields. Assumes nothing outside.
 */
package rsq_pkg;

	typedef enum logic [3:0] {
		RSQ_ST_ACTIVE = 4'h1,
		RSQ_ST_DELAY  = 4'h2,
		RSQ_ST_FETCH  = 4'h4,
		RSQ_ST_RUN    = 4'h8
	} rsq_state_t;

	typedef struct packed {
		logic pin;
		logic low_supply_detector;
		logic wdg;
	} rsq_cause_t;

	typedef struct packed {
		logic aux_irq_enable;
		logic aux_low_flag;
		logic low_supply_reset_flag;
		logic watchdog_reset_flag;
	} rsq_status_t;

endpackage

// file: hw/rsq_sync.sv
/*
 * Two-flop level synchroniser, W bits wide.
 * Assumes the inputs change no faster than the clock can follow.
 */
`timescale 1ns/10ps
module rsq_sync
	import rsq_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         aclk,    // System clock
	input  wire logic         aresetn, // Synchronous reset, active low
	input  wire logic [W-1:0] d,       // Asynchronous levels
	output logic      [W-1:0] q        // Synchronised levels
);
	logic [W-1:0] meta_q;

	generate
		if (W < 1) begin : g_chk
			$error("rsq_sync: W must be at least 1");
		end
	endgenerate

	// First stage is read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// file: hw/rsq_delay.sv
/*
 * Stabilisation delay counter. Counts clock cycles while run is high and
 * flags the last one; clears whenever run drops.
 * Assumes run stays high until done has been seen.
 */
`timescale 1ns/10ps
`include "rsq_regs.svh"
module rsq_delay
	import rsq_pkg::*;
#(
	parameter int SHORT = `RSQ_DELAY_SHORT,
	parameter int LONG  = `RSQ_DELAY_LONG,
	parameter int CW    = $clog2(LONG + 1)
) (
	input  wire logic aclk,     // System clock
	input  wire logic aresetn,  // Synchronous reset, active low
	input  wire logic run,      // Count this cycle
	input  wire logic long_sel, // Choose the long delay
	output logic      done      // Last cycle of the delay
);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] last;

	generate
		if (SHORT < 1 || LONG < SHORT) begin : g_chk
			$error("rsq_delay: need 1 <= SHORT <= LONG");
		end
	endgenerate

	assign last = long_sel ? CW'(LONG - 1) : CW'(SHORT - 1);
	assign done = run && (cnt_q == last);

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_q <= '0;
		end else if (!done) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end
endmodule

// file: hw/rsq_top.sv
/*
 * Reset sequencer and supply monitor of an 8-bit controller: merges pin,
 * low-supply and watchdog reset causes, drives the open-drain reset pin,
 * times the stabilisation delay and the vector fetch, and holds the
 * supply status register behind an AXI4-Lite slave.
 * Assumes comparator outputs and option bits are steady levels and that
 * the watchdog request is at least one cycle wide.
 */
// How it works
// - Three reset causes: reset pin low, low supply, watchdog request.
// - Any cause drives the reset pin low, held through the delay.
// - Vector fetch presents addresses FFFE then FFFF to the CPU.
// - Delay of 256 or 4096 cycles, chosen by option bit.
// - Vector fetch phase lasts exactly two cycles, then run.
// - Low reset pin is caught without a running clock.
// - Watchdog reset drives pin low at least the minimum pulse width.
// - Low supply keeps static reset and pin low while present.
// - Low-supply reset acts only when its option bit enables it.
// - Aux low flag is read-only, follows comparator, writes ignored.
// - Aux detector, flag and interrupt inactive when low-supply option off.
// - Each toggle of aux flag raises an interrupt when enabled.
// - Enabling with flag set raises an interrupt at once.
// - Aux interrupt reaches CPU only if enabled and CPU mask clear.
// - In wait mode logic runs and aux interrupt wakes the device.
// - In halt mode aux flag frozen, writes ignored, aux events do not wake.
// - Pending aux interrupt clears when CPU enters its service routine.
// - Bit 4 set by low-supply reset, cleared by writing zero only.
// - Bit 0 set by watchdog reset, cleared by zero write or low supply.
// - Bit 6 enable, bit 5 flag; bits 7 and 3..1 read zero.
`timescale 1ns/10ps
`include "rsq_regs.svh"
module rsq_top
	import rsq_pkg::*;
#(
	parameter int ADDR_W       = 8,
	parameter int SHORT_DELAY  = `RSQ_DELAY_SHORT,
	parameter int LONG_DELAY   = `RSQ_DELAY_LONG,
	parameter int WDG_PULSE_NS = `RSQ_WDG_PULSE_NS,
	parameter int CLK_MHZ      = `RSQ_CLK_MHZ
) (
	input  wire logic              aclk,            // System clock
	input  wire logic              aresetn,         // Sync reset, low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // Write address
	input  wire logic              s_axi_awvalid,   // Write address valid
	output logic                   s_axi_awready,   // Write address ready
	input  wire logic [31:0]       s_axi_wdata,     // Write data
	input  wire logic [3:0]        s_axi_wstrb,     // Write strobes
	input  wire logic              s_axi_wvalid,    // Write data valid
	output logic                   s_axi_wready,    // Write data ready
	output logic [1:0]             s_axi_bresp,     // Write response
	output logic                   s_axi_bvalid,    // Write resp valid
	input  wire logic              s_axi_bready,    // Write resp ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,    // Read address
	input  wire logic              s_axi_arvalid,   // Read address valid
	output logic                   s_axi_arready,   // Read address ready
	output logic [31:0]            s_axi_rdata,     // Read data
	output logic [1:0]             s_axi_rresp,     // Read response
	output logic                   s_axi_rvalid,    // Read data valid
	input  wire logic              s_axi_rready,    // Read data ready
	input  wire logic              rst_pin_n,       // Reset pin level
	output logic                   rst_pin_drv_n,   // Pin drive value
	output logic                   rst_pin_oe,      // Pin pulled low
	input  wire logic              low_supply_cmp,  // Supply below thr.
	input  wire logic              aux_voltage_cmp, // Aux comparator
	input  wire logic              wdg_reset_req,   // Watchdog underflow
	input  wire logic              opt_lvd_enable,  // Option: detector
	input  wire logic              opt_long_delay,  // Option: 4096 delay
	input  wire logic              cpu_irq_mask,    // CPU interrupt mask
	input  wire logic              cpu_isr_enter,   // Aux ISR entered
	input  wire logic              wait_mode,       // CPU in wait
	input  wire logic              halt_mode,       // CPU in halt
	output logic                   cpu_reset_n,     // Core held in reset
	output logic                   vec_fetch,       // Vector fetch phase
	output logic [15:0]            vec_addr,        // Vector byte address
	output logic                   aux_irq_req,     // Interrupt to CPU
	output logic                   wait_wake        // Wake from wait
);
	localparam int WDG_CYC_RAW = (WDG_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int WDG_CYC     = (WDG_CYC_RAW < 1) ? 1 : WDG_CYC_RAW;
	localparam int WW          = $clog2(WDG_CYC + 1);

	generate
		if (ADDR_W < 3 || ADDR_W > 32 || CLK_MHZ < 1) begin : g_chk
			$error("rsq_top: ADDR_W must be 3..32, CLK_MHZ positive");
		end
	endgenerate

	rsq_state_t  st_q;
	rsq_state_t  st_d;
	rsq_cause_t  cause;
	rsq_status_t sts_q;
	logic        pin_cap_q;
	logic [3:0]  sync_q;
	logic [2:0]  guard_q;
	logic [WW-1:0] wdg_cnt_q;
	logic        fcnt_q;
	logic        dly_done;
	logic        cause_any;
	logic        avd_live;
	logic        avd_prev_q;
	logic        pend_q;
	logic        aw_full_q;
	logic        w_full_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_do;
	logic        wr_hit;
	logic        wr_en_byte;
	logic        set_en;
	logic        sts_rd;

	always_ff @(posedge aclk or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			pin_cap_q <= 1'b1;
		end else begin
			pin_cap_q <= 1'b0;
		end
	end

	rsq_sync #(
		.W(4)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({pin_cap_q, low_supply_cmp, aux_voltage_cmp,
			wdg_reset_req}),
		.q       (sync_q)
	);

	// Own drive reads back low; ignore pin until it has risen
	always_ff @(posedge aclk) begin
		if (!aresetn || rst_pin_oe) begin
			guard_q <= `RSQ_PIN_GUARD;
		end else if (guard_q != 3'h0) begin
			guard_q <= guard_q - 3'h1;
		end
	end

	always_comb begin
		cause.pin = sync_q[3] && !rst_pin_oe && (guard_q == 3'h0);
		cause.low_supply_detector = sync_q[2] && opt_lvd_enable;
		cause.wdg = sync_q[0];
	end
	assign cause_any = cause.pin || cause.low_supply_detector || cause.wdg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdg_cnt_q <= '0;
		end else if (cause.wdg) begin
			wdg_cnt_q <= WW'(WDG_CYC);
		end else if (wdg_cnt_q != '0) begin
			wdg_cnt_q <= wdg_cnt_q - WW'(1);
		end
	end

	always_comb begin
		st_d = st_q;
		if (cause_any) begin
			st_d = RSQ_ST_ACTIVE;
		end else begin
			unique case (st_q)
				RSQ_ST_ACTIVE: begin
					if (wdg_cnt_q == '0) st_d = RSQ_ST_DELAY;
				end
				RSQ_ST_DELAY: begin
					if (dly_done) st_d = RSQ_ST_FETCH;
				end
				RSQ_ST_FETCH: begin
					if (fcnt_q) st_d = RSQ_ST_RUN;
				end
				RSQ_ST_RUN: begin
					st_d = RSQ_ST_RUN;
				end
				default: begin
					st_d = RSQ_ST_ACTIVE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= RSQ_ST_ACTIVE;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || st_q != RSQ_ST_FETCH) begin
			fcnt_q <= 1'b0;
		end else begin
			fcnt_q <= 1'b1;
		end
	end

	rsq_delay #(
		.SHORT(SHORT_DELAY),
		.LONG (LONG_DELAY)
	) u_delay (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.run      (st_q == RSQ_ST_DELAY),
		.long_sel (opt_long_delay),
		.done     (dly_done)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_pin_oe    <= 1'b1;
			rst_pin_drv_n <= 1'b0;
			cpu_reset_n   <= 1'b0;
		end else begin
			rst_pin_oe    <= (st_d == RSQ_ST_ACTIVE)
				|| (st_d == RSQ_ST_DELAY);
			rst_pin_drv_n <= 1'b0;
			cpu_reset_n   <= (st_d == RSQ_ST_FETCH)
				|| (st_d == RSQ_ST_RUN);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vec_fetch <= 1'b0;
			vec_addr  <= `RSQ_VEC_LO;
		end else begin
			vec_fetch <= (st_d == RSQ_ST_FETCH);
			vec_addr  <= (st_q == RSQ_ST_FETCH && st_d == RSQ_ST_FETCH)
				? `RSQ_VEC_HI : `RSQ_VEC_LO;
		end
	end

	// AXI4-Lite write: address and data taken in either order
	assign wr_do      = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wr_hit     = (awaddr_q[ADDR_W-1:2]
		== (ADDR_W-2)'(`RSQ_OFS_SUPPLY_CTRL_STATUS >> 2));
	assign wr_en_byte = wr_do && wr_hit && wstrb_q[0] && !halt_mode;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q     <= 1'b0;
			s_axi_awready <= 1'b0;
			awaddr_q      <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_q     <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_q      <= s_axi_awaddr;
		end else begin
			aw_full_q     <= aw_full_q && !wr_do;
			s_axi_awready <= !aw_full_q || wr_do;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_q     <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_q     <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
		end else begin
			w_full_q     <= w_full_q && !wr_do;
			s_axi_wready <= !w_full_q || wr_do;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RSQ_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read: one outstanding
	assign sts_rd = (s_axi_araddr[ADDR_W-1:2]
		== (ADDR_W-2)'(`RSQ_OFS_SUPPLY_CTRL_STATUS >> 2));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `RSQ_RST_RDATA;
			s_axi_rresp   <= `RSQ_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= sts_rd ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
			s_axi_rdata   <= `RSQ_RST_RDATA;
			if (sts_rd) begin
				s_axi_rdata[`RSQ_BIT_AUX_IRQ_ENABLE]  <= sts_q.aux_irq_enable;
				s_axi_rdata[`RSQ_BIT_AUX_LOW_FLAG]    <= sts_q.aux_low_flag;
				s_axi_rdata[`RSQ_BIT_LOW_SUPPLY_RST_FLAG]
					<= sts_q.low_supply_reset_flag;
				s_axi_rdata[`RSQ_BIT_WATCHDOG_RST_FLAG]
					<= sts_q.watchdog_reset_flag;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	assign avd_live = sync_q[1] && opt_lvd_enable;
	assign set_en   = wr_en_byte && !sts_q.aux_irq_enable
		&& wdata_q[`RSQ_BIT_AUX_IRQ_ENABLE];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_q.aux_low_flag <= 1'b0;
			avd_prev_q         <= 1'b0;
		end else if (!halt_mode) begin
			sts_q.aux_low_flag <= avd_live;
			avd_prev_q         <= sts_q.aux_low_flag;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_q.low_supply_reset_flag <= 1'b0;
			sts_q.watchdog_reset_flag   <= 1'b0;
		end else begin
			if (cause.low_supply_detector) begin
				sts_q.low_supply_reset_flag <= 1'b1;
			end else if (wr_en_byte
				&& !wdata_q[`RSQ_BIT_LOW_SUPPLY_RST_FLAG]) begin
				sts_q.low_supply_reset_flag <= 1'b0;
			end
			if (cause.wdg) begin
				sts_q.watchdog_reset_flag <= 1'b1;
			end else if (cause.low_supply_detector || (wr_en_byte
				&& !wdata_q[`RSQ_BIT_WATCHDOG_RST_FLAG])) begin
				sts_q.watchdog_reset_flag <= 1'b0;
			end
		end
	end

	// Enable is cleared by any device reset
	always_ff @(posedge aclk) begin
		if (!aresetn || st_q == RSQ_ST_ACTIVE) begin
			sts_q.aux_irq_enable <= 1'b0;
		end else if (wr_en_byte) begin
			sts_q.aux_irq_enable <= wdata_q[`RSQ_BIT_AUX_IRQ_ENABLE];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || st_q == RSQ_ST_ACTIVE || !opt_lvd_enable) begin
			pend_q <= 1'b0;
		end else if (!halt_mode && ((sts_q.aux_irq_enable
			&& sts_q.aux_low_flag != avd_prev_q)
			|| (set_en && sts_q.aux_low_flag))) begin
			pend_q <= 1'b1;
		end else if (cpu_isr_enter) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_irq_req <= 1'b0;
			wait_wake   <= 1'b0;
		end else begin
			aux_irq_req <= pend_q && sts_q.aux_irq_enable
				&& !cpu_irq_mask && !halt_mode && !cpu_isr_enter;
			wait_wake   <= pend_q && sts_q.aux_irq_enable
				&& wait_mode && !halt_mode && !cpu_isr_enter;
		end
	end
endmodule

// file: testbench/rsq_pin_model.sv
/* External reset circuit sharing the open-drain reset pin, with pull-up.
 * Assumes the device pulls the wire low while its enable is high. */
`timescale 1ns/10ps
module rsq_pin_model (
	input  wire logic rst_pin_oe,    // Device pulls pin
	input  wire logic rst_pin_drv_n, // Device drive value
	input  wire logic ext_low,       // Outside circuit holds pin
	output logic      rst_pin_n      // Resolved wire level
);
	assign rst_pin_n = ((rst_pin_oe && !rst_pin_drv_n) || ext_low) ? 1'b0 : 1'b1;
endmodule

// file: testbench/rsq_top_chk.sv
/* Port checker of the reset sequencer and supply monitor.
 * Bound to rsq_top below; sees only its ports. */
`timescale 1ns/10ps
module rsq_top_chk #(
	parameter int SHORT_DELAY  = 4,
	parameter int LONG_DELAY   = 16,
	parameter int WDG_PULSE_NS = 100,
	parameter int CLK_MHZ      = 200
) (
	input wire logic        aclk,           // Clock
	input wire logic        aresetn,        // Sync reset, low
	input wire logic        s_axi_bvalid,   // Write resp valid
	input wire logic        s_axi_bready,   // Write resp ready
	input wire logic [1:0]  s_axi_bresp,    // Write response
	input wire logic        s_axi_rvalid,   // Read valid
	input wire logic        s_axi_rready,   // Read ready
	input wire logic [31:0] s_axi_rdata,    // Read data
	input wire logic        rst_pin_oe,     // Pin pulled low
	input wire logic        low_supply_cmp, // Low supply
	input wire logic        wdg_reset_req,  // Watchdog request
	input wire logic        opt_lvd_enable, // Detector option
	input wire logic        opt_long_delay, // Long delay option
	input wire logic        cpu_irq_mask,   // CPU mask
	input wire logic        wait_mode,      // Wait mode
	input wire logic        halt_mode,      // Halt mode
	input wire logic        cpu_reset_n,    // Core reset
	input wire logic        vec_fetch,      // Fetch phase
	input wire logic [15:0] vec_addr,       // Vector address
	input wire logic        aux_irq_req,    // Aux interrupt
	input wire logic        wait_wake       // Wake from wait
);
	localparam int WCYC = WDG_PULSE_NS * CLK_MHZ / 1000;
	logic [15:0] oe_cnt_q;
	logic        oe_q;
	logic        wdg_seen_q;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Length of the current pin-low episode
	always_ff @(posedge aclk) begin
		oe_q <= rst_pin_oe;
		if (!aresetn)
			oe_cnt_q <= 16'h0000;
		else if (rst_pin_oe)
			oe_cnt_q <= oe_q ? oe_cnt_q + 16'h0001 : 16'h0001;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wdg_seen_q <= 1'b0;
		else if (wdg_reset_req)
			wdg_seen_q <= 1'b1;
		else if (oe_q && !rst_pin_oe)
			wdg_seen_q <= 1'b0;
	end
	property p_fetch_len;
		$rose(vec_fetch) |=> vec_fetch ##1 !vec_fetch && cpu_reset_n;
	endproperty
	property p_vec_addr;
		$rose(vec_fetch) |-> vec_addr == 16'hFFFE ##1 vec_addr == 16'hFFFF;
	endproperty
	property p_pin_held;
		!cpu_reset_n |-> rst_pin_oe;
	endproperty
	property p_delay;
		$rose(vec_fetch) |->
			oe_cnt_q >= (opt_long_delay ? LONG_DELAY : SHORT_DELAY);
	endproperty
	property p_wdg;
		$fell(rst_pin_oe) && wdg_seen_q |-> oe_cnt_q >= WCYC;
	endproperty
	property p_lvd_hold;
		(opt_lvd_enable && low_supply_cmp)[*6] |-> rst_pin_oe && !cpu_reset_n;
	endproperty
	property p_lvd_off;
		(!opt_lvd_enable)[*4] |-> !aux_irq_req;
	endproperty
	property p_irq_gate;
		aux_irq_req |-> !$past(cpu_irq_mask) && !$past(halt_mode);
	endproperty
	property p_wake;
		wait_wake |-> $past(wait_mode) && !$past(halt_mode);
	endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_fetch_len: assert property (p_fetch_len)
		else $error("fetch phase not two cycles");
	a_vec_addr: assert property (p_vec_addr)
		else $error("vector address order wrong");
	a_pin_held: assert property (p_pin_held)
		else $error("pin released while core in reset");
	a_delay: assert property (p_delay)
		else $error("stabilisation delay too short");
	a_wdg: assert property (p_wdg)
		else $error("watchdog pin pulse too short");
	a_lvd_hold: assert property (p_lvd_hold)
		else $error("low supply not holding reset");
	a_lvd_off: assert property (p_lvd_off)
		else $error("aux interrupt with detector off");
	a_irq_gate: assert property (p_irq_gate)
		else $error("aux interrupt not gated");
	a_wake: assert property (p_wake)
		else $error("wake outside wait mode");
	a_bhold: assert property (p_bhold)
		else $error("write response dropped early");
	a_rhold: assert property (p_rhold)
		else $error("read data dropped early");
	c_fetch: cover property ($rose(vec_fetch));
	c_wdg: cover property ($fell(rst_pin_oe) && wdg_seen_q);
	c_irq: cover property ($rose(aux_irq_req));
endmodule

bind rsq_top rsq_top_chk #(
	.SHORT_DELAY(SHORT_DELAY),
	.LONG_DELAY(LONG_DELAY),
	.WDG_PULSE_NS(WDG_PULSE_NS),
	.CLK_MHZ(CLK_MHZ)
) u_chk (.*);

// file: testbench/rsq_top_tb.sv
/* Self-checking bench of rsq_top with the external reset partner.
 * Assumes rsq_pkg, rsq_top, rsq_pin_model and the bound checker. */
`timescale 1ns/10ps
`include "rsq_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module rsq_top_tb;
	import rsq_pkg::*;
	localparam int SD = 4;
	localparam int LD = 16;
	localparam int WC = 20;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [1:0]  resp;
		logic [31:0] rdata;
	} rsq_row_t;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, rr;
	logic [15:0] vec_addr;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, rst_pin_n, ext_low;
	logic rst_pin_drv_n, rst_pin_oe, low_supply_cmp, aux_voltage_cmp;
	logic wdg_reset_req, opt_lvd_enable, opt_long_delay, cpu_irq_mask;
	logic cpu_isr_enter, wait_mode, halt_mode, cpu_reset_n, vec_fetch;
	logic aux_irq_req, wait_wake;
	int fails, checks, n;
	rsq_row_t rows[5] = '{
		'{8'h00, 32'h0000_00FF, `RSQ_RESP_OKAY, 32'h0000_0040},
		'{8'h00, 32'hFFFF_FF3F, `RSQ_RESP_OKAY, 32'h0000_0000},
		'{8'h04, 32'h0000_0040, `RSQ_RESP_SLVERR, 32'h0000_0000},
		'{8'hFC, 32'h0000_00FF, `RSQ_RESP_SLVERR, 32'h0000_0000},
		'{8'h00, 32'h0000_0000, `RSQ_RESP_OKAY, 32'h0000_0000}};
	rsq_top #(.SHORT_DELAY(SD), .LONG_DELAY(LD)) uut (.*);
	rsq_pin_model u_pin (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic time_out();
		fails++;
		$display("unexpected wait exp done got timeout");
		report_and_stop();
	endtask
	task automatic wait_for(ref logic s, input logic v, input int lim,
		output int c);
		for (c = 0; c < lim && s !== v; c++)
			@(posedge aclk);
		if (s !== v)
			time_out();
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 100 && s_axi_bvalid !== 1'b1; i++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		if (s_axi_bvalid !== 1'b1)
			time_out();
		// Late ready, so the response must stand while stalled
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 100 && s_axi_rvalid !== 1'b1; i++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		if (s_axi_rvalid !== 1'b1)
			time_out();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic reg_chk(input logic [31:0] e);
		axi_rd(8'h00, rd, rr);
		`CHK("status", e, rd)
	endtask
	task automatic isr();
		@(posedge aclk) cpu_isr_enter <= 1'b1;
		@(posedge aclk) cpu_isr_enter <= 1'b0;
	endtask
	task automatic boot(input logic low_supply_detector, input logic lng);
		@(posedge aclk) aresetn <= 1'b0;
		opt_lvd_enable <= low_supply_detector;
		opt_long_delay <= lng;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		wait_for(vec_fetch, 1'b1, 5000, n);
		`CHK("delay", (lng ? LD : SD) + 2, n)
		`CHK("vec lo", 16'hFFFE, vec_addr)
		@(posedge aclk);
		`CHK("vec hi", 16'hFFFF, vec_addr)
		@(posedge aclk);
		`CHK("fetch end", 2'b01, {vec_fetch, cpu_reset_n})
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, ext_low, low_supply_cmp} = 4'h0;
		{aux_voltage_cmp, wdg_reset_req, opt_long_delay} = 3'h0;
		{cpu_irq_mask, cpu_isr_enter, wait_mode, halt_mode} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		opt_lvd_enable = 1'b1;
		fails = 0;
		checks = 0;
		boot(1'b1, 1'b0);
		foreach (rows[k]) begin
			axi_wr(rows[k].addr, rows[k].wdata, rs);
			`CHK("bresp", rows[k].resp, rs)
			axi_rd(rows[k].addr, rd, rr);
			`CHK("rresp", rows[k].resp, rr)
			`CHK("rdata", rows[k].rdata, rd)
		end
		@(posedge aclk) wdg_reset_req <= 1'b1;
		@(posedge aclk) wdg_reset_req <= 1'b0;
		wait_for(rst_pin_n, 1'b0, 10, n);
		wait_for(rst_pin_n, 1'b1, 500, n);
		`CHK("wdg pulse", 1'b1, n >= WC + SD)
		wait_for(cpu_reset_n, 1'b1, 50, n);
		reg_chk(32'h0000_0001);
		@(posedge aclk) low_supply_cmp <= 1'b1;
		repeat (40) @(posedge aclk);
		`CHK("lvd pin", 1'b0, rst_pin_n)
		low_supply_cmp <= 1'b0;
		wait_for(cpu_reset_n, 1'b1, 200, n);
		reg_chk(32'h0000_0010);
		@(posedge aclk) halt_mode <= 1'b1;
		ext_low <= 1'b1;
		repeat (5) @(posedge aclk);
		ext_low <= 1'b0;
		halt_mode <= 1'b0;
		wait_for(cpu_reset_n, 1'b0, 20, n);
		wait_for(cpu_reset_n, 1'b1, 200, n);
		reg_chk(32'h0000_0010);
		axi_wr(8'h00, 32'h0000_0000, rs);
		reg_chk(32'h0000_0000);
		axi_wr(8'h00, 32'h0000_0040, rs);
		@(posedge aclk) aux_voltage_cmp <= 1'b1;
		wait_for(aux_irq_req, 1'b1, 10, n);
		reg_chk(32'h0000_0060);
		isr();
		wait_for(aux_irq_req, 1'b0, 3, n);
		@(posedge aclk) cpu_irq_mask <= 1'b1;
		aux_voltage_cmp <= 1'b0;
		repeat (8) @(posedge aclk);
		`CHK("masked irq", 1'b0, aux_irq_req)
		cpu_irq_mask <= 1'b0;
		wait_mode <= 1'b1;
		wait_for(wait_wake, 1'b1, 5, n);
		`CHK("fall irq", 1'b1, aux_irq_req)
		isr();
		wait_mode <= 1'b0;
		aux_voltage_cmp <= 1'b1;
		wait_for(aux_irq_req, 1'b1, 10, n);
		isr();
		axi_wr(8'h00, 32'h0000_0000, rs);
		axi_wr(8'h00, 32'h0000_0040, rs);
		wait_for(aux_irq_req, 1'b1, 10, n);
		isr();
		@(posedge aclk) halt_mode <= 1'b1;
		aux_voltage_cmp <= 1'b0;
		axi_wr(8'h00, 32'h0000_0000, rs);
		repeat (8) @(posedge aclk);
		`CHK("halt irq", 1'b0, aux_irq_req)
		reg_chk(32'h0000_0060);
		halt_mode <= 1'b0;
		boot(1'b0, 1'b1);
		axi_wr(8'h00, 32'h0000_0040, rs);
		@(posedge aclk) low_supply_cmp <= 1'b1;
		aux_voltage_cmp <= 1'b1;
		repeat (12) @(posedge aclk);
		`CHK("lvd off", 3'b110, {rst_pin_n, cpu_reset_n, aux_irq_req})
		reg_chk(32'h0000_0040);
		report_and_stop();
	end
endmodule
